//--- verilog/internal_reset_sources.sv
// Internal reset collector: watchdog, stack pointer, low-voltage, reset pin.
// Assumes stack pointer, restart strobe and supply flag are synchronous.
`timescale 1ns/1ps
`default_nettype none
module internal_reset_sources
    import reset_ctl_pkg::*;
#(
    parameter bit low_voltage_fitted = 1'b1,
    parameter int WDT_CYCLES = WDT_PERIOD_CYC,
    parameter int SETTLE_CYCLES = SETTLE_CYC,
    parameter int LVD_CYCLES = LVD_CYC
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Core status
    input wire logic watchdog_restart_flag,
    input wire logic [2:0] stack_ptr,
    input wire logic push_req,
    input wire logic pop_req,
    input wire logic in_standby,
    // Supply monitor
    input wire logic low_supply,
    // Reset pin, open drain
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    // Combined reset and run status
    output logic core_reset,
    output logic core_run,
    output logic standby_reset,
    // State defined by every reset; a standby reset keeps carrier, window and RAM without the scrub
    output logic [12:0] program_counter,
    output logic [23:0] port_dir_out,
    output logic [23:0] port_latch,
    output logic [15:0] data_buffer_reg,
    output logic [3:0] system_register_group,
    output logic [7:0] timer8_counter,
    output logic [7:0] timer8_modulo,
    output logic [7:0] wdt_counter,
    output logic [7:0] carrier_high_modulo,
    output logic [7:0] carrier_low_modulo,
    output logic [3:0] window_reg,
    output logic ram_clear
);
    seq_state_t state_q;
    logic [CNT_W-1:0] wdt_cnt_q;
    logic [CNT_W-1:0] settle_q;
    logic wdt_fire_q;
    logic sp_fire_q;
    logic lvd_expired;
    logic lvd_fire;
    logic ext_fire;
    logic any_src;

    // Source only counts once the supply flag has lasted
    persist_cnt #(.LIMIT(LVD_CYCLES)) u_lvd (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .level(low_supply),
        .expired(lvd_expired)
    );
    assign lvd_fire = low_voltage_fitted && lvd_expired;
    // Pin read only when we are not pulling it ourselves
    assign ext_fire = !reset_pin_in && !reset_pin_oe;
    assign any_src = wdt_fire_q || sp_fire_q || lvd_fire || ext_fire;

    // Watchdog counts only while running
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || state_q != ST_RUN)
        begin
            wdt_cnt_q <= '0;
            wdt_fire_q <= 1'b0;
        end
        else if (wdt_cnt_q >= CNT_W'(WDT_CYCLES - 1))
        begin
            // Expiry wins over a restart landing in the same cycle
            wdt_fire_q <= 1'b1;
        end
        else if (watchdog_restart_flag)
        begin
            wdt_cnt_q <= '0;
            wdt_fire_q <= 1'b0;
        end
        else
        begin
            wdt_cnt_q <= wdt_cnt_q + CNT_W'(1);
        end
    end

    // Stack pointer checks
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || state_q != ST_RUN)
        begin
            sp_fire_q <= 1'b0;
        end
        else if (stack_ptr == SP_TRIG_A || stack_ptr == SP_TRIG_B)
        begin
            sp_fire_q <= 1'b1;
        end
        else if ((push_req && stack_ptr == SP_EMPTY)
            || (pop_req && stack_ptr >= SP_DEEPEST))
        begin
            sp_fire_q <= 1'b1;
        end
        else
        begin
            sp_fire_q <= 1'b0;
        end
    end

    // Sequencer: hold, settle, run
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || any_src)
        begin
            state_q <= ST_RESET;
            settle_q <= '0;
        end
        else
        begin
            unique case (state_q)
                ST_RESET:
                begin
                    state_q <= ST_SETTLE;
                    settle_q <= '0;
                end
                ST_SETTLE:
                begin
                    if (settle_q >= CNT_W'(SETTLE_CYCLES - 1))
                    begin
                        state_q <= ST_RUN;
                    end
                    else
                    begin
                        settle_q <= settle_q + CNT_W'(1);
                    end
                end
                ST_RUN:
                begin
                    state_q <= ST_RUN;
                end
                default:
                begin
                    state_q <= ST_RESET;
                end
            endcase
        end
    end

    // Pin drive and status outputs
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            reset_pin_oe <= 1'b0;
            reset_pin_out <= 1'b0;
            core_reset <= 1'b1;
            core_run <= 1'b0;
            standby_reset <= 1'b0;
        end
        else
        begin
            // Pull-up is external; only drive low for internal sources
            reset_pin_oe <= wdt_fire_q || sp_fire_q || lvd_fire;
            reset_pin_out <= 1'b0;
            core_reset <= any_src || state_q != ST_RUN;
            core_run <= state_q == ST_RUN && !any_src;
            if (any_src && state_q == ST_RUN)
            begin
                standby_reset <= in_standby;
            end
        end
    end

    // State defined by every reset
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || any_src || state_q != ST_RUN)
        begin
            program_counter <= PC_RST;
            port_dir_out <= PORT_RST;
            port_latch <= PORT_RST;
            data_buffer_reg <= DATA_BUF_RST;
            system_register_group <= SYS_GROUP_RST;
            timer8_counter <= TIMER8_CNT_RST;
            timer8_modulo <= TIMER8_MOD_RST;
            wdt_counter <= WDT_CNT_RST;
        end
        else
        begin
            wdt_counter <= wdt_cnt_q[CNT_W-1 -: 8];
        end
    end

    // Retained in standby; operating reset scrubs to a known pattern
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || (any_src && state_q == ST_RUN && !in_standby))
        begin
            carrier_high_modulo <= UNDEF_BYTE;
            carrier_low_modulo <= UNDEF_BYTE;
            window_reg <= UNDEF_NIB;
            ram_clear <= rst_n;
        end
        else
        begin
            ram_clear <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- verilog/reset_ctl_pkg.sv
// Constants for the internal reset source collector.
// Assumes a single 50 MHz core clock and a synchronous active-low reset.
package reset_ctl_pkg;
    localparam int CLK_HZ = 50_000_000;
    // Watchdog period and settle wait kept in real time, not in clock counts
    localparam int WDT_PERIOD_MS_NUM = 340;
    localparam int WDT_PERIOD_CYC = (CLK_HZ / 1000) * WDT_PERIOD_MS_NUM;
    localparam int SETTLE_TIME_US_X1000 = 16_384;
    localparam int SETTLE_CYC = (CLK_HZ / 1000) * SETTLE_TIME_US_X1000 / 1000;
    localparam int LVD_TIME_MS = 1;
    localparam int LVD_CYC = (CLK_HZ / 1000) * LVD_TIME_MS;
    localparam int CNT_W = 25;
    // Stack pointer trigger values and limits
    localparam logic [2:0] SP_TRIG_A = 3'h6;
    localparam logic [2:0] SP_TRIG_B = 3'h7;
    localparam logic [2:0] SP_EMPTY = 3'h0;
    localparam logic [2:0] SP_DEEPEST = 3'h6;
    // Reset values of core and peripheral state
    localparam logic [12:0] PC_RST = 13'h0000;
    localparam logic [15:0] DATA_BUF_RST = 16'h0320;
    localparam logic [3:0] SYS_GROUP_RST = 4'h0;
    localparam logic [7:0] TIMER8_CNT_RST = 8'h00;
    localparam logic [7:0] TIMER8_MOD_RST = 8'hff;
    localparam logic [7:0] WDT_CNT_RST = 8'h00;
    localparam logic [23:0] PORT_RST = 24'h00_0000;
    localparam logic [3:0] UNDEF_NIB = 4'h0;
    localparam logic [7:0] UNDEF_BYTE = 8'h00;
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_SETTLE = 2'b01,
        ST_RUN = 2'b11
    } seq_state_t;
endpackage

//--- verilog/persist_cnt.sv
// Saturating counter that reports when an input level has lasted a set time.
// Assumes a synchronous input and active-low synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module persist_cnt
    import reset_ctl_pkg::*;
#(
    parameter int LIMIT = 16
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Level to time and result
    input wire logic level,
    output logic expired
);
    logic [CNT_W-1:0] cnt_q;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n || !level)
        begin
            cnt_q <= '0;
            expired <= 1'b0;
        end
        else if (cnt_q >= CNT_W'(LIMIT - 1))
        begin
            expired <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end
endmodule
`default_nettype wire

//--- sim/reset_props.sv
// Port checker for the reset collector.
// Assumes a bind to every internal_reset_sources.
`timescale 1ns/1ps
`default_nettype none
module reset_props
    import reset_ctl_pkg::*;
#(parameter int SETTLE_CYCLES = 20)
(
    // Core side
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [2:0] stack_ptr,
    input wire logic push_req,
    // Reset side
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe,
    input wire logic core_reset,
    input wire logic core_run,
    input wire logic [12:0] program_counter
);
    int idle_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Idle time bounds the settling wait from below
    always_ff @(posedge core_clk)
        idle_q <= (!rst_n || core_run) ? 0 : idle_q + 1;
    sequence s_sp_bad;
        core_run && (stack_ptr >= SP_TRIG_A || (push_req && stack_ptr == SP_EMPTY));
    endsequence
    a_sp_pull: assert property (s_sp_bad |-> ##[1:2] reset_pin_oe) else $error("sp");
    a_oe_reset: assert property (reset_pin_oe |-> core_reset) else $error("oe");
    a_pin_low: assert property (reset_pin_oe |-> !reset_pin_out) else $error("pin");
    a_run_excl: assert property (core_run |-> !core_reset) else $error("run");
    a_pc_zero: assert property (core_reset |-> program_counter == PC_RST) else $error("pc");
    a_start_zero: assert property ($rose(core_run) |-> program_counter == PC_RST) else $error("pc0");
    a_settle_wait: assert property ($rose(core_run) |-> idle_q >= SETTLE_CYCLES) else $error("wait");
    a_resettle: assert property ($fell(reset_pin_oe) |-> !core_run [*8]) else $error("gap");
endmodule
bind internal_reset_sources reset_props #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_props (.core_clk,
    .rst_n, .stack_ptr, .push_req, .reset_pin_out, .reset_pin_oe, .core_reset, .core_run,
    .program_counter);
`default_nettype wire

//--- sim/core_sw_model.sv
// Software and reset pin model.
// Assumes one clock; the pin has a pull-up.
`timescale 1ns/1ps
`default_nettype none
module core_sw_model
(
    // Commands
    input wire logic core_clk,
    input wire logic [7:0] kick_gap,
    input wire logic ext_low,
    // Pin and restart
    input wire logic reset_pin_oe,
    output logic reset_pin_in,
    output logic watchdog_restart_flag
);
    logic [7:0] gap_q = 8'h00;
    // Zero gap stops restarts so the watchdog expires
    always_ff @(posedge core_clk)
    begin
        gap_q <= (gap_q >= kick_gap) ? 8'h00 : gap_q + 8'h01;
        watchdog_restart_flag <= kick_gap != 8'h00 && gap_q == kick_gap;
    end
    assign reset_pin_in = !(reset_pin_oe || ext_low);
endmodule
`default_nettype wire

//--- sim/internal_reset_sources_tb_top.sv
// Bench for the reset collector.
// Assumes counts of 50, 20 and 10 cycles.
`timescale 1ns/1ps
`default_nettype none
module internal_reset_sources_tb_top
    import reset_ctl_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_n, push_req, pop_req, in_standby, low_supply, ext_low, kick, pin_in, pin_oe;
    logic core_reset, core_run, standby_reset, nolv_run, ram_clear;
    logic [2:0] stack_ptr;
    logic [3:0] sreg;
    logic [7:0] kick_gap, t8_cnt, t8_mod, wdc;
    logic [12:0] pc;
    logic [15:0] data_buf;
    logic [23:0] pdir, plat;
    int err_count, tests_run, cyc, k;
    wire logic [16:0] rst_view = {core_reset, core_run, pin_in, pc, pin_oe};
    internal_reset_sources #(.WDT_CYCLES(50), .SETTLE_CYCLES(20), .LVD_CYCLES(10)) dut (
        .core_clk, .rst_n, .watchdog_restart_flag(kick), .stack_ptr, .push_req, .pop_req,
        .in_standby, .low_supply, .reset_pin_in(pin_in), .reset_pin_out(), .reset_pin_oe(pin_oe),
        .core_reset, .core_run, .standby_reset, .program_counter(pc), .port_dir_out(pdir),
        .port_latch(plat), .data_buffer_reg(data_buf), .system_register_group(sreg),
        .timer8_counter(t8_cnt), .timer8_modulo(t8_mod), .wdt_counter(wdc),
        .carrier_high_modulo(), .carrier_low_modulo(), .window_reg(), .ram_clear);
    // Same core built without the supply source; it must ride through low supply
    internal_reset_sources #(.low_voltage_fitted(1'b0), .WDT_CYCLES(50), .SETTLE_CYCLES(20),
        .LVD_CYCLES(10)) dut_nolv (
        .core_clk, .rst_n, .watchdog_restart_flag(kick), .stack_ptr, .push_req, .pop_req,
        .in_standby, .low_supply, .reset_pin_in(!ext_low), .reset_pin_out(), .reset_pin_oe(),
        .core_reset(), .core_run(nolv_run), .standby_reset(), .program_counter(),
        .port_dir_out(), .port_latch(), .data_buffer_reg(), .system_register_group(),
        .timer8_counter(), .timer8_modulo(), .wdt_counter(), .carrier_high_modulo(),
        .carrier_low_modulo(), .window_reg(), .ram_clear());
    core_sw_model sw (.core_clk, .kick_gap, .ext_low, .reset_pin_oe(pin_oe),
        .reset_pin_in(pin_in), .watchdog_restart_flag(kick));
    always #10 core_clk = ~core_clk;
    // Ceiling well above the roughly 1,600 cycles the scenarios need
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_count++;
            stop_test();
        end
    end
    task automatic check(input string nm, input logic [127:0] got, exp);
        tests_run++;
        err_count += int'(got !== exp);
        if (got !== exp) $display("[FAIL] %s exp %h got %h", nm, exp, got);
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask
    task automatic wait_hi(ref logic s, input int lim);
        for (int i = 0; i < lim && s !== 1'b1; i++) tick(1);
    endtask
    function automatic logic [104:0] exp_state();
        return {PC_RST, DATA_BUF_RST, SYS_GROUP_RST, TIMER8_CNT_RST, TIMER8_MOD_RST, WDT_CNT_RST,
            PORT_RST, PORT_RST};
    endfunction
    task automatic stop_test();
        if (err_count == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial
    begin
        rst_n = 1'b0;
        {push_req, pop_req, in_standby, low_supply, ext_low, stack_ptr} = 8'h01;
        kick_gap = 8'h1e;
        k = $urandom(32'h76f4);
        tick(20);
        check("state", {pc, data_buf, sreg, t8_cnt, t8_mod, wdc, pdir, plat}, exp_state());
        rst_n <= 1'b1;
        wait_hi(core_run, 100);
        repeat (100)
        begin
            {stack_ptr, push_req, pop_req} <= {3'($urandom_range(5, 1)), 2'($urandom)};
            tick(1);
        end
        check("legal", core_run, 1'b1);
        // Cases: stack 6, stack 7, call at empty, return at 6, watchdog, supply, pin
        for (k = 0; k < 7; k++)
        begin
            stack_ptr <= (k == 2) ? SP_EMPTY : (k < 4 ? SP_TRIG_A | 3'(k == 1) : 3'h1);
            {push_req, pop_req, low_supply, in_standby, ext_low} <= {k == 2, k == 3, k == 5,
                k == 6, k == 6};
            kick_gap <= (k == 4) ? 8'h00 : 8'h1e;
            tick(1);
            {stack_ptr, push_req, pop_req} <= 5'h04;
            wait_hi(core_reset, 60);
            tick(k > 4 ? 600 : 0);
            check("rst", rst_view, {16'h8000, k != 6});
            check("scrub", ram_clear, k < 5);
            check("no_lv", nolv_run, k == 5);
            {low_supply, ext_low, kick_gap} <= {2'h0, 8'h1e};
            wait_hi(core_run, 100);
            check("wake", {core_run, standby_reset}, {1'b1, k == 6});
        end
        stop_test();
    end
endmodule
`default_nettype wire
